// [wes_regs.vh]
`ifndef WES_REGS_VH
`define WES_REGS_VH

// register indices as printed; byte address is four times the index
`define WES_IDX_ENABLE_ONE 8'hB0
`define WES_IDX_ENABLE_TWO 8'hB1
`define WES_IDX_STATUS_ONE 8'hB2
`define WES_IDX_STATUS_TWO 8'hB3
`define WES_IDX_IRQ_STATUS 8'hB4
`define WES_IDX_IRQ_MASK 8'hB5
`define WES_IDX_POWER_CTRL 8'hB6

// byte addresses on the register bus
`define WES_ADDR_ENABLE_ONE 12'h2C0
`define WES_ADDR_ENABLE_TWO 12'h2C4
`define WES_ADDR_STATUS_ONE 12'h2C8
`define WES_ADDR_STATUS_TWO 12'h2CC
`define WES_ADDR_IRQ_STATUS 12'h2D0
`define WES_ADDR_IRQ_MASK 12'h2D4
`define WES_ADDR_POWER_CTRL 12'h2D8

// status one fields
`define WES_S1_PORT_A_RING 0
`define WES_S1_PORT_B_RING 1
`define WES_S1_KEYBOARD 2
`define WES_S1_MOUSE 3
`define WES_S1_GROUP_A 4
`define WES_S1_GROUP_B 5
`define WES_S1_INFRARED_B 6
// status two fields
`define WES_S2_PORT_A_RX 0
`define WES_S2_PORT_B_RX 1
`define WES_S2_BUTTON 2
`define WES_S2_RING 3

// masks of implemented bits
`define WES_S1_LATCH_MASK 8'h4F
`define WES_S1_LIVE_MASK 8'h30
`define WES_S2_LATCH_MASK 8'h0F
`define WES_EN1_MASK 8'h7F
`define WES_EN2_MASK 8'hDB
`define WES_S2_POWER_MASK 8'h0B

// reset values
`define WES_EN1_RESET 8'h00
`define WES_EN2_RESET 8'h80
`define WES_STATUS_RESET 8'h00

// interrupt status bit positions
`define WES_IRQ_STATUS_ONE 0
`define WES_IRQ_STATUS_TWO 1

// axi responses
`define WES_RESP_OKAY 2'h0
`define WES_RESP_SLVERR 2'h2

`endif

// [wes_wake_status.v]
`timescale 1ns/1ps
`include "wes_regs.vh"

// Functional notes
// RULE1 - each status bit is one once its wake source occurred, zero after clear; status one bits 4 and 5 show the live group level instead
// RULE2 - status one bit 0 latches port A ring falling edge, read clears
// RULE3 - status one bit 1 latches port B ring falling edge, read clears
// RULE4 - status one bit 2 latches keyboard data falling edge, read clears
// RULE5 - status one bit 3 latches mouse data falling edge, held until read
// RULE6 - status one bit 6 latches infrared B falling edge, held until read
// RULE7 - status one bit 4 shows live group irq A, read does not clear
// RULE8 - status one bit 5 shows live group irq B, clears at source
// RULE9 - status two bit 0 latches port A rx falling edge, read clears
// RULE10 - status two bit 1 latches port B rx falling edge, read clears
// RULE11 - status two bit 3 latches ring input event, read clears
// RULE12 - status two bit 2 latches power button press, read clears
// RULE13 - button latch is status only, never drives power request
// RULE14 - edge events stay latched after the pin returns high
// RULE15 - group irq bits are never latched here
// RULE16 - a wake event requests power only if its enable bit is set
// RULE17 - reserved bits read zero, ignore writes; latches reset to zero
// RULE18 - read clears only bits returned; concurrent edge stays pending
module wes_wake_status #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // wake source pins, idle high
    input wire port_a_ring_in,
    input wire port_b_ring_in,
    input wire keyboard_line_in,
    input wire mouse_line_in,
    input wire infrared_rx_b_in,
    input wire port_a_rx_in,
    input wire port_b_rx_in,
    input wire ring_input_n_in,
    input wire power_button_n_in,
    // internal group interrupts, active high
    input wire group_irq_a_in,
    input wire group_irq_b_in,
    // axi4-lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output reg s_axi_awready_out,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output reg s_axi_wready_out,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    // axi4-lite read address
    input wire [ADDR_W-1:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output reg s_axi_arready_out,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    // outputs
    output reg power_request_out_n,
    output reg irq_out
);

    // pin history for edge detection
    reg [8:0] pin_prev_r;
    wire [8:0] pin_now;
    wire [8:0] pin_fall;

    reg [7:0] enable_one_r;
    reg [7:0] enable_two_r;
    reg [7:0] status_one_r;
    reg [7:0] status_two_r;
    reg [7:0] status_one_nxt;
    reg [7:0] status_two_nxt;
    reg [1:0] group_live_r;
    reg [1:0] irq_status_r;
    reg [1:0] irq_status_nxt;
    reg [1:0] irq_mask_r;
    reg power_force_r;

    // write channel capture
    reg aw_held_r;
    reg w_held_r;
    reg [ADDR_W-1:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg w_strb0_r;
    wire wr_fire;
    wire [ADDR_W-1:0] wr_target;
    wire [31:0] wr_word;
    wire wr_strb0;
    wire wr_to_en_one;
    wire wr_to_en_two;
    wire wr_to_st_one;
    wire wr_to_st_two;
    wire wr_to_irq_st;
    wire wr_to_irq_mask;
    wire wr_to_power;
    wire wr_mapped;

    // read side
    wire rd_fire;
    reg [31:0] rd_word;
    reg rd_hit;
    wire rd_status_one;
    wire rd_status_two;

    wire [7:0] edge_one;
    wire [7:0] edge_two;
    wire [7:0] status_one_view;
    wire [7:0] wake_one;
    wire [7:0] wake_two;

    function addr_is;
        input [ADDR_W-1:0] a;
        input [11:0] target;
        begin
            addr_is = ({{(32-ADDR_W){1'b0}}, a} & 32'hFFFFFFFC) ==
                      {20'h00000, target};
        end
    endfunction

    assign pin_now = {power_button_n_in, ring_input_n_in, port_b_rx_in,
                      port_a_rx_in, infrared_rx_b_in, mouse_line_in,
                      keyboard_line_in, port_b_ring_in, port_a_ring_in};
    assign pin_fall = pin_prev_r & ~pin_now;

    assign edge_one = {1'b0, pin_fall[4], 2'b00, pin_fall[3:0]};
    assign edge_two = {4'h0, pin_fall[7], pin_fall[8], pin_fall[6:5]};

    // live bits sampled once so reads see a stable level
    assign status_one_view = (status_one_r & `WES_S1_LATCH_MASK) |
                             {2'b00, group_live_r, 4'h0}; // RULE15

    assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
    assign rd_status_one = rd_fire &&
        addr_is(s_axi_araddr_in, `WES_ADDR_STATUS_ONE);
    assign rd_status_two = rd_fire &&
        addr_is(s_axi_araddr_in, `WES_ADDR_STATUS_TWO);

    // set beats clear, and clear removes only what the read returned
    always @* begin
        status_one_nxt = status_one_r;
        status_two_nxt = status_two_r;
        if (rd_status_one)
            status_one_nxt = 8'h00; // RULE18
        if (rd_status_two)
            status_two_nxt = 8'h00; // RULE12
        // RULE2 RULE3 RULE4 RULE5 RULE6 RULE14
        status_one_nxt = (status_one_nxt | edge_one) & `WES_S1_LATCH_MASK;
        // RULE9 RULE10 RULE11
        status_two_nxt = (status_two_nxt | edge_two) & `WES_S2_LATCH_MASK;
    end

    // wake qualifies only with its enable; button bit excluded
    assign wake_one = status_one_view & enable_one_r & `WES_EN1_MASK; // RULE16
    assign wake_two = status_two_r & enable_two_r & `WES_S2_POWER_MASK; // RULE13

    // a channel counts only once its own handshake happened
    assign wr_fire = (aw_held_r || (s_axi_awvalid_in && s_axi_awready_out)) &&
                     (w_held_r || (s_axi_wvalid_in && s_axi_wready_out)) &&
                     !s_axi_bvalid_out;

    // held or live channel, whichever arrived first
    assign wr_target = wr_addr(1'b0);
    assign wr_word = wr_data(1'b0);
    assign wr_strb0 = w_strb0_sel(1'b0);
    assign wr_to_en_one = addr_is(wr_target, `WES_ADDR_ENABLE_ONE);
    assign wr_to_en_two = addr_is(wr_target, `WES_ADDR_ENABLE_TWO);
    assign wr_to_st_one = addr_is(wr_target, `WES_ADDR_STATUS_ONE);
    assign wr_to_st_two = addr_is(wr_target, `WES_ADDR_STATUS_TWO);
    assign wr_to_irq_st = addr_is(wr_target, `WES_ADDR_IRQ_STATUS);
    assign wr_to_irq_mask = addr_is(wr_target, `WES_ADDR_IRQ_MASK);
    assign wr_to_power = addr_is(wr_target, `WES_ADDR_POWER_CTRL);
    assign wr_mapped = wr_to_en_one || wr_to_en_two || wr_to_st_one ||
                       wr_to_st_two || wr_to_irq_st || wr_to_irq_mask ||
                       wr_to_power;

    always @* begin
        rd_hit = 1'b1;
        rd_word = 32'h00000000;
        if (addr_is(s_axi_araddr_in, `WES_ADDR_ENABLE_ONE))
            rd_word = {24'h000000, enable_one_r};
        else if (addr_is(s_axi_araddr_in, `WES_ADDR_ENABLE_TWO))
            rd_word = {24'h000000, enable_two_r};
        else if (addr_is(s_axi_araddr_in, `WES_ADDR_STATUS_ONE))
            rd_word = {24'h000000, status_one_view}; // RULE1 RULE7 RULE8
        else if (addr_is(s_axi_araddr_in, `WES_ADDR_STATUS_TWO))
            rd_word = {24'h000000, status_two_r}; // RULE17
        else if (addr_is(s_axi_araddr_in, `WES_ADDR_IRQ_STATUS))
            rd_word = {30'h00000000, irq_status_r};
        else if (addr_is(s_axi_araddr_in, `WES_ADDR_IRQ_MASK))
            rd_word = {30'h00000000, irq_mask_r};
        else if (addr_is(s_axi_araddr_in, `WES_ADDR_POWER_CTRL))
            rd_word = {31'h00000000, power_force_r};
        else
            rd_hit = 1'b0;
    end

    // interrupt events: any new latched wake per register
    always @* begin
        irq_status_nxt = irq_status_r;
        if (wr_fire && wr_strb0 && wr_to_irq_st)
            irq_status_nxt = irq_status_r & ~wr_word[1:0];
        if (|edge_one)
            irq_status_nxt[`WES_IRQ_STATUS_ONE] = 1'b1;
        if (|edge_two)
            irq_status_nxt[`WES_IRQ_STATUS_TWO] = 1'b1;
    end

    function w_strb0_sel;
        input dummy;
        begin
            w_strb0_sel = w_held_r ? w_strb0_r : s_axi_wstrb_in[0];
        end
    endfunction

    function [ADDR_W-1:0] wr_addr;
        input dummy;
        begin
            wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr_in;
        end
    endfunction

    function [31:0] wr_data;
        input dummy;
        begin
            wr_data = w_held_r ? w_data_r : s_axi_wdata_in;
        end
    endfunction

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_prev_r <= 9'h1FF;
            enable_one_r <= `WES_EN1_RESET;
            enable_two_r <= `WES_EN2_RESET;
            status_one_r <= `WES_STATUS_RESET; // RULE17
            status_two_r <= `WES_STATUS_RESET;
            group_live_r <= 2'h0;
            irq_status_r <= 2'h0;
            irq_mask_r <= 2'h0;
            power_force_r <= 1'b0;
            power_request_out_n <= 1'b1;
            irq_out <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= {ADDR_W{1'b0}};
            w_data_r <= 32'h00000000;
            w_strb0_r <= 1'b0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `WES_RESP_OKAY;
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `WES_RESP_OKAY;
        end else begin
            pin_prev_r <= pin_now;
            group_live_r <= {group_irq_b_in, group_irq_a_in}; // RULE7 RULE8
            status_one_r <= status_one_nxt;
            status_two_r <= status_two_nxt;
            irq_status_r <= irq_status_nxt;
            irq_out <= |(irq_status_nxt & irq_mask_r);
            power_request_out_n <= ~(power_force_r | (|wake_one) |
                                     (|wake_two)); // RULE16

            // write address and data taken in either order
            s_axi_awready_out <= !aw_held_r && !s_axi_awvalid_in_taken(1'b0);
            s_axi_wready_out <= !w_held_r && !s_axi_wvalid_in_taken(1'b0);
            if (s_axi_awvalid_in && s_axi_awready_out && !wr_fire) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out && !wr_fire) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_in;
                w_strb0_r <= s_axi_wstrb_in[0];
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_awready_out <= 1'b0;
                s_axi_wready_out <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= `WES_RESP_OKAY;
                if (wr_strb0) begin
                    if (wr_to_en_one)
                        enable_one_r <= wr_word[7:0] & `WES_EN1_MASK;
                    else if (wr_to_en_two)
                        enable_two_r <= wr_word[7:0] & `WES_EN2_MASK;
                    else if (wr_to_irq_mask)
                        irq_mask_r <= wr_word[1:0];
                    else if (wr_to_power)
                        power_force_r <= wr_word[0];
                end
                // status one and two are read-only: writes ignored
                if (!wr_mapped)
                    s_axi_bresp_out <= `WES_RESP_SLVERR; // RULE17
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end

            // one read at a time
            s_axi_arready_out <= !s_axi_rvalid_out && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_word;
                s_axi_rresp_out <= rd_hit ? `WES_RESP_OKAY : `WES_RESP_SLVERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // ready is withheld while a response is still pending
    function s_axi_awvalid_in_taken;
        input dummy;
        begin
            s_axi_awvalid_in_taken = s_axi_bvalid_out || wr_fire;
        end
    endfunction

    function s_axi_wvalid_in_taken;
        input dummy;
        begin
            s_axi_wvalid_in_taken = s_axi_bvalid_out || wr_fire;
        end
    endfunction

endmodule // wes_wake_status

// [wes_src_model.sv]
`timescale 1ns/1ps
// wake sources: pins idle high, each strobe gives a 3-cycle low pulse
module wes_src_model (
    // clock and strobes
    input wire sys_clk_in,
    input wire [8:0] pulse_in,
    // source pins
    output wire [8:0] pins_out
);
    reg [8:0] d1_r = 9'h000;
    reg [8:0] d2_r = 9'h000;
    always @(posedge sys_clk_in) begin
        d1_r <= pulse_in;
        d2_r <= d1_r;
    end
    // long enough that a one-clock edge detector cannot miss it
    assign pins_out = ~(pulse_in | d1_r | d2_r);
endmodule // wes_src_model

// [wes_wake_status_props.sv]
`timescale 1ns/1ps
`include "wes_regs.vh"
module wes_wake_status_props #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // register bus
    input wire s_axi_awvalid_in,
    input wire s_axi_awready_out,
    input wire s_axi_wvalid_in,
    input wire s_axi_wready_out,
    input wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [ADDR_W-1:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    input wire s_axi_arready_out,
    input wire [31:0] s_axi_rdata_out,
    input wire [1:0] s_axi_rresp_out,
    input wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    // outputs
    input wire power_request_out_n,
    input wire irq_out
);
    reg [ADDR_W-1:0] rd_addr_r = {ADDR_W{1'b0}};
    wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
    wire aw_hs = s_axi_awvalid_in && s_axi_awready_out;
    wire w_hs = s_axi_wvalid_in && s_axi_wready_out;
    // byte lanes inside a word select the same register
    wire [ADDR_W-1:0] rd_word_addr = {rd_addr_r[ADDR_W-1:2], 2'b00};
    wire mapped = rd_word_addr >= `WES_ADDR_ENABLE_ONE &&
        rd_word_addr <= `WES_ADDR_POWER_CTRL;
    always @(posedge sys_clk_in) begin
        if (ar_hs) begin
            rd_addr_r <= s_axi_araddr_in;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_read_answer: assert property (ar_hs |=> s_axi_rvalid_out)
        else $error("read handshake without data next cycle");
    a_write_answer: assert property (aw_hs && w_hs |=> s_axi_bvalid_out)
        else $error("write handshake without response next cycle");
    a_rdata_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped before taken");
    a_bresp_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out) else $error("write response dropped");
    a_one_resv_zero: assert property (s_axi_rvalid_out &&
        rd_addr_r == `WES_ADDR_STATUS_ONE |-> s_axi_rdata_out[31:7] == 25'h0)
        else $error("status one reserved bits not zero");
    a_two_resv_zero: assert property (s_axi_rvalid_out &&
        rd_addr_r == `WES_ADDR_STATUS_TWO |-> s_axi_rdata_out[31:4] == 28'h0)
        else $error("status two reserved bits not zero");
    a_unmapped_err: assert property (s_axi_rvalid_out && !mapped |->
        s_axi_rresp_out == `WES_RESP_SLVERR && s_axi_rdata_out == 32'h0)
        else $error("unmapped read not refused");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |=>
        !s_axi_rvalid_out && !s_axi_bvalid_out && power_request_out_n && !irq_out)
        else $error("outputs active after reset");
    c_read: cover property (ar_hs ##1 s_axi_rvalid_out);
    c_write: cover property (aw_hs && w_hs);
    c_irq: cover property ($rose(irq_out));
    c_power: cover property ($fell(power_request_out_n));
endmodule // wes_wake_status_props
bind wes_wake_status wes_wake_status_props #(.ADDR_W(ADDR_W)) chk_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .irq_out(irq_out),
    .power_request_out_n(power_request_out_n));

// [wes_wake_status_tb_top.sv]
`timescale 1ns/1ps
`include "wes_regs.vh"
module wes_wake_status_tb_top;
    reg clk = 1'b0, rst_n = 1'b0, ga = 1'b0, gb = 1'b0;
    reg [8:0] pulse = 9'h000;
    reg [11:0] awaddr = 12'h000, araddr = 12'h000;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0;
    wire [8:0] pins;
    wire awready, wready, bvalid, arready, rvalid, pwr_n, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer err_total = 0, samples_checked = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    wes_src_model src_u (.sys_clk_in(clk), .pulse_in(pulse), .pins_out(pins));
    wes_wake_status dut_u (.sys_clk_in(clk), .rst_n_in(rst_n),
        .port_a_ring_in(pins[0]), .port_b_ring_in(pins[1]),
        .keyboard_line_in(pins[2]), .mouse_line_in(pins[3]),
        .infrared_rx_b_in(pins[4]), .port_a_rx_in(pins[5]),
        .port_b_rx_in(pins[6]), .ring_input_n_in(pins[7]),
        .power_button_n_in(pins[8]), .group_irq_a_in(ga), .group_irq_b_in(gb),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .power_request_out_n(pwr_n), .irq_out(irq));
    task automatic results;
        $display("mismatches %0d of %0d checks", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // writes a register and compares the response
    task automatic wr(input [11:0] a, input [7:0] d, input [1:0] er);
        integer n;
        reg done;
        n = 0;
        done = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            n = n + 1;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                done = 1'b1;
                bready <= 1'b0;
                chk({30'h0, bresp}, {30'h0, er});
            end else if (bvalid) begin
                // late ready: the response must stand a cycle
                bready <= 1'b1;
            end
            if (n > 100) begin
                err_total = err_total + 1;
                results();
            end
        end
        tick(1);
    endtask
    // reads a register and compares data and response
    task automatic rexp(input [11:0] a, input [31:0] exp, input [1:0] er);
        integer n;
        reg done;
        n = 0;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            n = n + 1;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                done = 1'b1;
                rready <= 1'b0;
                chk(rdata, exp);
                chk({30'h0, rresp}, {30'h0, er});
            end else if (rvalid) begin
                // late ready: the data must stand a cycle
                rready <= 1'b1;
            end
            if (n > 100) begin
                err_total = err_total + 1;
                results();
            end
        end
        tick(1);
    endtask
    task automatic fire(input [8:0] m);
        pulse <= m;
        tick(1);
        pulse <= 9'h000;
        tick(8);
    endtask
    task automatic t_reset;
        rexp(`WES_ADDR_STATUS_ONE, 32'h00, 2'h0);
        rexp(`WES_ADDR_STATUS_TWO, 32'h00, 2'h0);
        rexp(`WES_ADDR_ENABLE_TWO, 32'h80, 2'h0);
        rexp(12'h100, 32'h0, `WES_RESP_SLVERR);
    endtask
    task automatic t_status_one;
        fire(9'h01F);
        rexp(`WES_ADDR_STATUS_ONE, 32'h4F, 2'h0);
        rexp(`WES_ADDR_STATUS_ONE, 32'h00, 2'h0);
        wr(`WES_ADDR_STATUS_ONE, 8'hFF, 2'h0);
        rexp(`WES_ADDR_STATUS_ONE, 32'h00, 2'h0);
    endtask
    task automatic t_group;
        ga <= 1'b1;
        tick(3);
        rexp(`WES_ADDR_STATUS_ONE, 32'h10, 2'h0);
        rexp(`WES_ADDR_STATUS_ONE, 32'h10, 2'h0);
        ga <= 1'b0; gb <= 1'b1;
        tick(3);
        rexp(`WES_ADDR_STATUS_ONE, 32'h20, 2'h0);
        gb <= 1'b0;
        tick(3);
        rexp(`WES_ADDR_STATUS_ONE, 32'h00, 2'h0);
    endtask
    task automatic t_status_two;
        fire(9'h1E0);
        rexp(`WES_ADDR_STATUS_TWO, 32'h0F, 2'h0);
        rexp(`WES_ADDR_STATUS_TWO, 32'h00, 2'h0);
    endtask
    task automatic t_power;
        wr(`WES_ADDR_ENABLE_TWO, 8'h01, 2'h0);
        fire(9'h140);
        chk({31'h0, pwr_n}, 32'h1);
        fire(9'h020);
        chk({31'h0, pwr_n}, 32'h0);
        rexp(`WES_ADDR_STATUS_TWO, 32'h07, 2'h0);
        tick(3);
        chk({31'h0, pwr_n}, 32'h1);
        wr(`WES_ADDR_ENABLE_TWO, 8'h80, 2'h0);
    endtask
    task automatic t_irq;
        wr(`WES_ADDR_IRQ_STATUS, 8'h03, 2'h0);
        wr(`WES_ADDR_IRQ_MASK, 8'h01, 2'h0);
        rexp(`WES_ADDR_IRQ_MASK, 32'h01, 2'h0);
        fire(9'h004);
        chk({31'h0, irq}, 32'h1);
        rexp(`WES_ADDR_IRQ_STATUS, 32'h01, 2'h0);
        rexp(`WES_ADDR_STATUS_ONE, 32'h04, 2'h0);
        wr(`WES_ADDR_IRQ_STATUS, 8'h01, 2'h0);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        wr(`WES_ADDR_IRQ_MASK, 8'h00, 2'h0);
        fire(9'h004);
        chk({31'h0, irq}, 32'h0);
    endtask
    // edge lands in the same cycle as the clearing read
    task automatic t_race;
        pulse <= 9'h004;
        rexp(`WES_ADDR_STATUS_ONE, 32'h00, 2'h0);
        pulse <= 9'h000;
        tick(4);
        rexp(`WES_ADDR_STATUS_ONE, 32'h04, 2'h0);
    endtask
    // keyboard bit still latched from the irq scenario
    task automatic t_enable;
        chk({31'h0, pwr_n}, 32'h1);
        wr(`WES_ADDR_ENABLE_ONE, 8'hFF, 2'h0);
        rexp(`WES_ADDR_ENABLE_ONE, 32'h7F, 2'h0);
        chk({31'h0, pwr_n}, 32'h0);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(2);
        chk({31'h0, pwr_n}, 32'h1);
        rexp(`WES_ADDR_STATUS_ONE, 32'h00, 2'h0);
        rexp(`WES_ADDR_ENABLE_ONE, 32'h00, 2'h0);
        wr(`WES_ADDR_POWER_CTRL, 8'h01, 2'h0);
        chk({31'h0, pwr_n}, 32'h0);
        rexp(`WES_ADDR_POWER_CTRL, 32'h01, 2'h0);
        wr(`WES_ADDR_POWER_CTRL, 8'h00, 2'h0);
        wr(12'h100, 8'h55, `WES_RESP_SLVERR);
        chk({31'h0, pwr_n}, 32'h1);
    endtask
    initial begin
        tick(2);
        rst_n <= 1'b1;
        tick(2);
        t_reset();
        t_status_one();
        t_group();
        t_status_two();
        t_race();
        t_power();
        t_irq();
        t_enable();
        results();
    end
endmodule // wes_wake_status_tb_top
